// file: gcp_map.vh
// Summary of operation
// - pump wobble enable bit set selects spread-spectrum charge pump; resets to 0.
// - pwm wobble enable bit set selects spread-spectrum pwm frequency; resets to 0.
// - analog select 01 temperature, 10 band-gap, 00/11 disabled; resets to 00.
// - regulator enable bit turns the 5 V regulator on; resets to 1.
// - step pin select 0 ignores input one; step position changes only by writes.
// - step pin select 1 (reset) uses input one as step; step position read-only.
// - direction pin select 0 ignores input two; direction changes only by writes.
// - direction pin select 1 (reset) takes direction from input two, reads it back.
// - third pin field 01 step mode, 10 hold, 00/11 off; resets to 00.
// - output one select: 00 off, 01 ready, 10 lower limit, 11 run.
// - output two select: 00 off, 01 pwm on-time, 10 error, 11 ec signal.
// - rising step edge increments position when direction 0, decrements when 1.
// - step mode function with step pin active: input three high picks alternate mode.
// - hold function makes hold bit read-only, mirroring input three.
`ifndef GCP_MAP_VH
`define GCP_MAP_VH
`define GCP_ADDR_W       3
`define GCP_ADDR_CFG1    3'h3
`define GCP_ADDR_CFG2    3'h4
`define GCP_ADDR_MOTOR1  3'h5
`define GCP_CFG1_MASK    16'hDC2E
`define GCP_CFG2_MASK    16'h0D80
`define GCP_MOT1_MASK    16'h40FE
`define GCP_CFG1_RST     16'h0428
`define GCP_CFG2_RST     16'h0000
`define GCP_MOT1_RST     16'h0000
`define GCP_B_PUMP_WOB   15
`define GCP_B_PWM_WOB    14
`define GCP_B_ANALOG_OUTPUT_SELECT_HI    12
`define GCP_B_ANALOG_OUTPUT_SELECT_LO    11
`define GCP_B_REG_EN     10
`define GCP_B_STEP_SEL   5
`define GCP_B_DIR_SEL    3
`define GCP_B_P3_HI      2
`define GCP_B_P3_LO      1
`define GCP_B_DO1_HI     11
`define GCP_B_DO1_LO     10
`define GCP_B_DO2_HI     8
`define GCP_B_DO2_LO     7
`define GCP_B_HOLD       14
`define GCP_B_DIR        7
`define GCP_B_PH_HI      6
`define GCP_B_PH_LO      1
`define GCP_FN_OFF       2'h0
`define GCP_FN_STEP_MODE_SELECT_FUNCTION     2'h1
`define GCP_FN_HOLD      2'h2
`define GCP_ANALOG_OUTPUT_SELECT_TEMP    2'h1
`define GCP_ANALOG_OUTPUT_SELECT_BGAP    2'h2
`endif

// file: gcp_sync.v
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for asynchronous pins
module gcp_sync #(
	parameter W = 3
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	// first stage feeds only the second stage
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;
endmodule // gcp_sync
`default_nettype wire

// file: gcp_top.v
`timescale 1ns/100ps
`default_nettype none
`include "gcp_map.vh"
// global configuration and pin function registers
module gcp_top (
	input  wire                   ref_clk,
	input  wire                   nrst,
	input  wire [`GCP_ADDR_W-1:0] reg_addr,
	input  wire                   reg_wr,
	input  wire [15:0]            reg_wdata,
	output reg  [15:0]            reg_rdata,
	input  wire                   control_input_one,
	input  wire                   control_input_two,
	input  wire                   control_input_three,
	input  wire                   coil_voltage_ready,
	input  wire                   coil_voltage_lower_limit,
	input  wire                   coil_voltage_run,
	input  wire                   pwm_on_time,
	input  wire                   error_flag,
	input  wire                   ec_signal,
	output reg                    pump_wobble_enable,
	output reg                    pwm_wobble_enable,
	output reg                    temp_out_enable,
	output reg                    bandgap_out_enable,
	output reg                    regulator_enable,
	output reg                    alt_step_mode_active,
	output reg                    hold_mode_bit,
	output reg                    direction,
	output reg  [5:0]             step_position,
	output reg                    digital_output_one,
	output reg                    digital_output_two
);
	// reset release
	reg        rst_meta_r;
	reg        rst_n_r;
	wire       rst_n;
	// synchronised pins and step edge history
	wire [2:0] pins_s;
	reg        step_d_r;
	// configuration storage
	reg [15:0] cfg1_r;
	reg [15:0] cfg2_r;
	// motor-side fields shared with the pin functions
	reg        hold_r;
	reg        dir_r;
	reg [5:0]  pos_r;
	reg [5:0]  pos_nxt;
	reg        dir_nxt;
	reg        hold_nxt;
	// combinational next values of the outputs
	reg [15:0] rdata_nxt;
	reg        do1_nxt;
	reg        do2_nxt;
	reg        temp_nxt;
	reg        bandgap_nxt;
	wire       alt_nxt;
	// field decode
	wire       step_sel;
	wire       dir_sel;
	wire [1:0] p3_fn;
	reg        step_mode_select_function_fn;
	reg        hold_fn;
	wire [1:0] analog_output_select;
	wire [1:0] do1_sel;
	wire [1:0] do2_sel;
	wire       step_rise;
	wire       dir_eff;
	wire       hold_eff;
	// write strobes per register
	wire       wr_cfg1;
	wire       wr_cfg2;
	wire       wr_mot1;

	// reset release through two flops
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end
	assign rst_n = rst_n_r;

	// pins are asynchronous to ref_clk
	gcp_sync #(
		.W (3)
	) gcp_sync_i (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     ({control_input_three, control_input_two, control_input_one}),
		.q     (pins_s)
	);

	assign step_sel = cfg1_r[`GCP_B_STEP_SEL];
	assign dir_sel  = cfg1_r[`GCP_B_DIR_SEL];
	assign p3_fn    = cfg1_r[`GCP_B_P3_HI:`GCP_B_P3_LO];
	assign analog_output_select     = cfg1_r[`GCP_B_ANALOG_OUTPUT_SELECT_HI:`GCP_B_ANALOG_OUTPUT_SELECT_LO];
	assign do1_sel  = cfg2_r[`GCP_B_DO1_HI:`GCP_B_DO1_LO];
	assign do2_sel  = cfg2_r[`GCP_B_DO2_HI:`GCP_B_DO2_LO];
	assign wr_cfg1  = reg_wr && (reg_addr == `GCP_ADDR_CFG1);
	assign wr_cfg2  = reg_wr && (reg_addr == `GCP_ADDR_CFG2);
	assign wr_mot1  = reg_wr && (reg_addr == `GCP_ADDR_MOTOR1);

	// third pin function decode; both 00 and 11 leave the pin unused
	always @* begin
		step_mode_select_function_fn = 1'b0;
		hold_fn  = 1'b0;
		case (p3_fn)
			`GCP_FN_STEP_MODE_SELECT_FUNCTION: begin
				step_mode_select_function_fn = 1'b1;
			end
			`GCP_FN_HOLD: begin
				hold_fn = 1'b1;
			end
			default: begin
				step_mode_select_function_fn = 1'b0;
				hold_fn  = 1'b0;
			end
		endcase
	end

	// analog source decode; both 00 and 11 leave the output off
	always @* begin
		temp_nxt    = 1'b0;
		bandgap_nxt = 1'b0;
		case (analog_output_select)
			`GCP_ANALOG_OUTPUT_SELECT_TEMP: begin
				temp_nxt = 1'b1;
			end
			`GCP_ANALOG_OUTPUT_SELECT_BGAP: begin
				bandgap_nxt = 1'b1;
			end
			default: begin
				temp_nxt    = 1'b0;
				bandgap_nxt = 1'b0;
			end
		endcase
	end

	// alternate mode needs the step pin function as well
	assign alt_nxt = step_sel && step_mode_select_function_fn && pins_s[2];

	// edge detect on the synchronised copy only
	// history starts low, the idle level of the step pin
	assign step_rise = pins_s[0] && !step_d_r && step_sel;
	assign dir_eff   = dir_sel ? pins_s[1] : dir_r;
	assign hold_eff  = hold_fn ? pins_s[2] : hold_r;

	// motor-side fields touched by pin functions
	always @* begin
		pos_nxt  = pos_r;
		dir_nxt  = dir_r;
		hold_nxt = hold_r;
		if (wr_mot1 && !step_sel) begin
			pos_nxt = reg_wdata[`GCP_B_PH_HI:`GCP_B_PH_LO];
		end else if (step_rise) begin
			if (dir_eff) begin
				pos_nxt = pos_r - 6'h01;
			end else begin
				pos_nxt = pos_r + 6'h01;
			end
		end
		// pin levels are kept so the bit holds them once the pin is released
		if (dir_sel) begin
			dir_nxt = pins_s[1];
		end else if (wr_mot1) begin
			dir_nxt = reg_wdata[`GCP_B_DIR];
		end
		if (hold_fn) begin
			hold_nxt = pins_s[2];
		end else if (wr_mot1) begin
			hold_nxt = reg_wdata[`GCP_B_HOLD];
		end
	end

	// register storage; reserved bits masked off
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg1_r   <= `GCP_CFG1_RST;
			cfg2_r   <= `GCP_CFG2_RST;
			pos_r    <= 6'h00;
			dir_r    <= 1'b0;
			hold_r   <= 1'b0;
			step_d_r <= 1'b0;
		end else begin
			if (wr_cfg1) begin
				cfg1_r <= reg_wdata & `GCP_CFG1_MASK;
			end
			if (wr_cfg2) begin
				cfg2_r <= reg_wdata & `GCP_CFG2_MASK;
			end
			pos_r    <= pos_nxt;
			dir_r    <= dir_nxt;
			hold_r   <= hold_nxt;
			step_d_r <= pins_s[0];
		end
	end

	// read mux; parity bit left zero, framing adds it
	always @* begin
		case (reg_addr)
			`GCP_ADDR_CFG1: begin
				rdata_nxt = cfg1_r;
			end
			`GCP_ADDR_CFG2: begin
				rdata_nxt = cfg2_r;
			end
			`GCP_ADDR_MOTOR1: begin
				rdata_nxt = 16'h0000;
				rdata_nxt[`GCP_B_HOLD] = hold_eff;
				rdata_nxt[`GCP_B_DIR] = dir_eff;
				rdata_nxt[`GCP_B_PH_HI:`GCP_B_PH_LO] = pos_r;
			end
			default: begin
				rdata_nxt = 16'h0000;
			end
		endcase
	end

	// output selectors
	always @* begin
		case (do1_sel)
			2'h1: do1_nxt = coil_voltage_ready;
			2'h2: do1_nxt = coil_voltage_lower_limit;
			2'h3: do1_nxt = coil_voltage_run;
			default: do1_nxt = 1'b0;
		endcase
		case (do2_sel)
			2'h1: do2_nxt = pwm_on_time;
			2'h2: do2_nxt = error_flag;
			2'h3: do2_nxt = ec_signal;
			default: do2_nxt = 1'b0;
		endcase
	end

	// read word registered so the host samples a settled value
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

	// configuration levels; regulator starts on so sensors get supply
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pump_wobble_enable <= 1'b0;
			pwm_wobble_enable  <= 1'b0;
			regulator_enable   <= 1'b1;
		end else begin
			pump_wobble_enable <= cfg1_r[`GCP_B_PUMP_WOB];
			pwm_wobble_enable  <= cfg1_r[`GCP_B_PWM_WOB];
			regulator_enable   <= cfg1_r[`GCP_B_REG_EN];
		end
	end

	// analog enables; decoded ahead of the flop so the mux never glitches
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_out_enable    <= 1'b0;
			bandgap_out_enable <= 1'b0;
		end else begin
			temp_out_enable    <= temp_nxt;
			bandgap_out_enable <= bandgap_nxt;
		end
	end

	// pin function outputs
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alt_step_mode_active <= 1'b0;
			hold_mode_bit        <= 1'b0;
		end else begin
			alt_step_mode_active <= alt_nxt;
			hold_mode_bit        <= hold_eff;
		end
	end

	// effective motor fields as the driver core consumes them
	// position shown is the stored count, never raw write data
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			direction     <= 1'b0;
			step_position <= 6'h00;
		end else begin
			direction     <= dir_eff;
			step_position <= pos_r;
		end
	end

	// digital outputs lag their sources by one cycle
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			digital_output_one <= 1'b0;
			digital_output_two <= 1'b0;
		end else begin
			digital_output_one <= do1_nxt;
			digital_output_two <= do2_nxt;
		end
	end
endmodule // gcp_top
`default_nettype wire

// file: gcp_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// port-level checks on the configuration bank
module gcp_top_monitor (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic [2:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        coil_voltage_ready,
	input wire logic        ec_signal,
	input wire logic        pump_wobble_enable,
	input wire logic        pwm_wobble_enable,
	input wire logic        temp_out_enable,
	input wire logic        bandgap_out_enable,
	input wire logic        regulator_enable,
	input wire logic        digital_output_one,
	input wire logic        digital_output_two
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// write to the first config word
	wire w1 = reg_wr && reg_addr == 3'h3;
	property p_pump; w1 |-> ##2 pump_wobble_enable == $past(reg_wdata[15], 2); endproperty
	a_pump: assert property (p_pump) else $error("pump wobble");
	property p_pwm; w1 |-> ##2 pwm_wobble_enable == $past(reg_wdata[14], 2); endproperty
	a_pwm: assert property (p_pwm) else $error("pwm wobble");
	property p_analog_output_select; w1 |-> ##2 {temp_out_enable, bandgap_out_enable} ==
		{$past(reg_wdata[12:11], 2) == 2'h1, $past(reg_wdata[12:11], 2) == 2'h2}; endproperty
	a_analog_output_select: assert property (p_analog_output_select) else $error("analog select");
	property p_reg; w1 |-> ##2 regulator_enable == $past(reg_wdata[10], 2); endproperty
	a_reg: assert property (p_reg) else $error("regulator");
	// settled select, then the output trails its source by one cycle
	property p_do1; reg_wr && reg_addr == 3'h4 && reg_wdata[11:10] == 2'h1 ##1 !reg_wr [*3]
		|-> digital_output_one == $past(coil_voltage_ready); endproperty
	a_do1: assert property (p_do1) else $error("output one");
	property p_do2; reg_wr && reg_addr == 3'h4 && reg_wdata[8:7] == 2'h3 ##1 !reg_wr [*3]
		|-> digital_output_two == $past(ec_signal); endproperty
	a_do2: assert property (p_do2) else $error("output two");
	property p_rsv; reg_addr == 3'h3 |=> (reg_rdata & 16'h23D1) == 16'h0000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits");
	property p_rsv2; reg_addr == 3'h4 |=> (reg_rdata & 16'hF27F) == 16'h0000; endproperty
	a_rsv2: assert property (p_rsv2) else $error("reserved bits two");
	property p_unm; reg_addr < 3'h3 || reg_addr > 3'h5 |=> reg_rdata == 16'h0000; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
endmodule // gcp_top_monitor
bind gcp_top gcp_top_monitor gcp_top_monitor_i (.*);
`default_nettype wire

// file: gcp_host_pins.sv
`timescale 1ns/100ps
`default_nettype none
// host pin driver: one step pulse per request, edges off the clock
module gcp_host_pins (
	input  wire logic clk,
	input  wire logic go,
	input  wire logic dir_lvl,
	input  wire logic third_lvl,
	output var logic  pin_step,
	output wire logic pin_dir,
	output wire logic pin_third,
	output var logic  busy
);
	assign pin_dir = dir_lvl;
	assign pin_third = third_lvl;
	// pulse wide enough to survive the two-flop sync
	initial begin
		pin_step = 1'h0;
		busy = 1'h0;
		forever begin
			@(posedge clk iff go);
			busy = 1'h1;
			#2 pin_step = 1'h1;
			repeat (4) @(posedge clk);
			#2 pin_step = 1'h0;
			repeat (4) @(posedge clk);
			busy = 1'h0;
		end
	end
endmodule // gcp_host_pins
`default_nettype wire

// file: global_config_pin_function_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module global_config_pin_function_regs_bench;
	logic        ref_clk, nrst, reg_wr, go, dl, tl, busy;
	wire         p1, p2, p3, pw, mw, te, be, re, am, hm, dr, d1, d2;
	logic [2:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [5:0]  src, sp;
	int          err_total, checks_done, i;
	// addr, write data, read back, {pump,pwm,temp,bandgap,reg,out1,out2}
	logic [41:0] rows [10] = '{{3'h3, 16'hFFFF, 16'hDC2E, 7'h64}, {3'h3, 16'h0829, 16'h0828, 7'h10},
		{3'h3, 16'h1428, 16'h1428, 7'h0C}, {3'h3, 16'h8428, 16'h8428, 7'h44},
		{3'h3, 16'h0428, 16'h0428, 7'h04},
		{3'h4, 16'hFFFF, 16'h0D80, 7'h07}, {3'h4, 16'h0500, 16'h0500, 7'h06},
		{3'h4, 16'h0880, 16'h0880, 7'h05}, {3'h4, 16'h0000, 16'h0000, 7'h04},
		{3'h7, 16'hFFFF, 16'h0000, 7'h04}};
	gcp_top gcp_top_i (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .control_input_one(p1),
		.control_input_two(p2), .control_input_three(p3), .coil_voltage_ready(src[5]),
		.coil_voltage_lower_limit(src[4]), .coil_voltage_run(src[3]), .pwm_on_time(src[2]),
		.error_flag(src[1]), .ec_signal(src[0]), .pump_wobble_enable(pw),
		.pwm_wobble_enable(mw), .temp_out_enable(te), .bandgap_out_enable(be),
		.regulator_enable(re), .alt_step_mode_active(am), .hold_mode_bit(hm), .direction(dr),
		.step_position(sp), .digital_output_one(d1), .digital_output_two(d2));
	gcp_host_pins gcp_host_pins_i (.clk(ref_clk), .go(go), .dir_lvl(dl), .third_lvl(tl),
		.pin_step(p1), .pin_dir(p2), .pin_third(p3), .busy(busy));
	task chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task finish_test;
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// inputs move a fixed 2 ns after the edge
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	task wr(input logic [2:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		cyc(1);
		reg_wr = 1'h0;
		cyc(3);
	endtask
	task step;
		int n;
		go = 1'h1;
		cyc(1);
		go = 1'h0;
		for (n = 0; n < 30 && busy; n++) cyc(1);
		if (busy) begin
			err_total++;
			finish_test;
		end
		cyc(5);
	endtask
	initial begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		nrst = 1'h0; reg_wr = 1'h0; reg_addr = 3'h3; reg_wdata = 16'h0000;
		go = 1'h0; dl = 1'h0; tl = 1'h0; src = 6'h2D; err_total = 0; checks_done = 0;
		cyc(6);
		nrst = 1'h1;
		cyc(3);
		chk(reg_rdata, 16'h0428);
		chk(16'({pw, mw, te, be, re, d1, d2}), 16'h0004);
		// table of plain writes with readback and decoded outputs
		for (i = 0; i < 10; i++) begin
			wr(rows[i][41:39], rows[i][38:23]);
			chk(reg_rdata, rows[i][22:7]);
			chk(16'({pw, mw, te, be, re, d1, d2}), 16'(rows[i][6:0]));
		end
		// pin-driven stepping under reset selects, then selects cleared, alternate step mode and hold
		step;
		chk(16'(sp), 16'h0001);
		dl = 1'h1;
		cyc(4);
		chk(16'(dr), 16'h0001);
		step;
		chk(16'(sp), 16'h0000);
		wr(3'h5, 16'h007E);
		chk(16'({dr, sp}), 16'h0040);
		wr(3'h3, 16'h0400);
		step;
		chk(16'(sp), 16'h0000);
		dl = 1'h0;
		wr(3'h5, 16'h008A);
		chk(16'({dr, sp}), 16'h0045);
		chk(reg_rdata, 16'h008A);
		wr(3'h3, 16'h0422);
		tl = 1'h1;
		cyc(4);
		chk(16'(am), 16'h0001);
		wr(3'h3, 16'h0426);
		chk(16'(am), 16'h0000);
		wr(3'h3, 16'h0424);
		wr(3'h5, 16'h0000);
		chk(16'(hm), 16'h0001);
		// mid-run reset returns every field to its default
		wr(3'h3, 16'hFFFF);
		nrst = 1'h0;
		cyc(2);
		chk(16'({pw, mw, te, be, re, d1, d2}), 16'h0004);
		chk(16'(sp), 16'h0000);
		nrst = 1'h1;
		cyc(3);
		chk(reg_rdata, 16'h0428);
		chk(16'({dr, sp}), 16'h0000);
		finish_test;
	end
endmodule // global_config_pin_function_regs_bench
`default_nettype wire
